// *** rtl/cctl_ctrl.v ***
// Control, bit timing, error counter and interrupt logic of a CAN controller
//
// Summary of operation
// - Bit timed from prop+phase1, phase2 and jump width, all in quanta.
// - One quantum equals clock period times programmable divisor.
// - Bit length is prop+phase1 plus phase2 plus one sync quantum.
// - Bit rate is clock over bit quanta times divisor.
// - While disabled, no transmit or receive processing happens.
// - Disable keeps all internal state and message objects intact.
// - Once enabled, pending transmits go out and received frames are handled.
// - After reset the controller stays disabled until the host enables it.
// - Error counters readable with error-passive flag.
// - Clear request takes status identifier or object number 1 to 32.
// - Reading the status register clears a pending status interrupt.
// - Reading a message object clears its pending interrupt.
// - Each interrupt source has its own enable gating the interrupt.
// - Global enable gates every controller interrupt.
// - Cause reads status identifier or highest-priority pending object.
// - Lower object numbers have higher priority.
`timescale 1ns/1ps
`include "cctl_defs.vh"

module cctl_ctrl (
    // Clock and reset
    input  wire                     CLOCK,
    input  wire                     RSTN,
    // Enable and bit timing configuration
    input  wire                     ENABLE_SET,
    input  wire                     DISABLE_SET,
    input  wire                     TIMING_WRITE,
    input  wire [`CCTL_SEG1_W-1:0]  PROP_PHASE1_QUANTA,
    input  wire [`CCTL_SEG2_W-1:0]  PHASE2_QUANTA,
    input  wire [`CCTL_SJW_W-1:0]   RESYNC_JUMP_WIDTH,
    input  wire [`CCTL_DIV_W-1:0]   QUANTUM_DIVISOR,
    // Resynchronisation edge from the bus receiver
    input  wire                     BUS_RX,
    // Error counter events from the protocol engine
    input  wire                     TX_ERR_INC,
    input  wire                     TX_ERR_DEC,
    input  wire                     RX_ERR_INC,
    input  wire                     RX_ERR_DEC,
    // Interrupt events and transmit request
    input  wire                     STATUS_EVENT,
    input  wire [`CCTL_NOBJ-1:0]    OBJ_EVENT,
    input  wire                     OBJ_TX_PENDING,
    // Interrupt control
    input  wire                     INT_CLEAR,
    input  wire [`CCTL_ID_W-1:0]    INT_CLEAR_ID,
    input  wire                     STATUS_READ,
    input  wire                     OBJ_READ,
    input  wire [`CCTL_ID_W-1:0]    OBJ_READ_ID,
    input  wire                     STATUS_INT_EN,
    input  wire [`CCTL_NOBJ-1:0]    OBJ_INT_EN,
    input  wire                     GLOBAL_INT_EN,
    // Status outputs
    output reg                      ENABLED,
    output wire                     PROCESS_EN,
    output reg                      TX_START,
    output reg                      QUANTUM_TICK,
    output reg                      SAMPLE_POINT,
    output reg                      BIT_END,
    output reg  [7:0]               TX_ERR_COUNT,
    output reg  [7:0]               RX_ERR_COUNT,
    output reg                      ERR_PASSIVE,
    output reg  [`CCTL_ID_W-1:0]    INT_CAUSE,
    output reg  [`CCTL_NOBJ-1:0]    OBJ_INT_PENDING,
    output reg                      STATUS_INT_PENDING,
    output reg                      INT_OUT
);

// ----------------------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------------------
// Maps object number 1..32 to a one-hot clear mask; other numbers give zero
function [`CCTL_NOBJ-1:0] obj_mask;
    input [`CCTL_ID_W-1:0] id;
    begin
        if (id >= 6'h01 && id <= 6'h20)
            obj_mask = {{(`CCTL_NOBJ-1){1'b0}}, 1'b1} << (id - 6'h01);
        else
            obj_mask = {`CCTL_NOBJ{1'b0}};
    end
endfunction

// Saturating 8-bit step counter
function [7:0] err_step;
    input [7:0] cnt;
    input       inc;
    input       dec;
    begin
        if (inc && !dec && cnt != 8'hFF)
            err_step = cnt + 8'h01;
        else if (dec && !inc && cnt != 8'h00)
            err_step = cnt - 8'h01;
        else
            err_step = cnt;
    end
endfunction

// ----------------------------------------------------------------------------
// Enable control and timing registers
// ----------------------------------------------------------------------------
reg  [`CCTL_SEG1_W-1:0] seg1;
reg  [`CCTL_SEG2_W-1:0] seg2;
reg  [`CCTL_SJW_W-1:0]  sjw;
reg  [`CCTL_DIV_W-1:0]  divisor;

// Timing is only taken while disabled so a running bit is never reshaped
always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
        ENABLED <= 1'b0;
        seg1    <= `CCTL_RST_SEG1;
        seg2    <= `CCTL_RST_SEG2;
        sjw     <= `CCTL_RST_SJW;
        divisor <= `CCTL_RST_DIV;
    end else begin
        if (ENABLE_SET)
            ENABLED <= 1'b1;
        else if (DISABLE_SET)
            ENABLED <= 1'b0;
        if (TIMING_WRITE && !ENABLED) begin
            seg1    <= PROP_PHASE1_QUANTA;
            seg2    <= PHASE2_QUANTA;
            sjw     <= RESYNC_JUMP_WIDTH;
            // A zero divisor would wrap the prescaler compare to 63 and give 64-cycle quanta, so it runs as one
            if (QUANTUM_DIVISOR == 6'h00)
                divisor <= `CCTL_RST_DIV;
            else
                divisor <= QUANTUM_DIVISOR;
        end
    end
end

assign PROCESS_EN = ENABLED;

// ----------------------------------------------------------------------------
// Bus receive synchroniser
// ----------------------------------------------------------------------------
reg rx_s1;
reg rx_s2;
reg rx_s3;
reg rx_level;

always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
        rx_s1    <= 1'b1;
        rx_s2    <= 1'b1;
        rx_s3    <= 1'b1;
        rx_level <= 1'b1;
    end else begin
        rx_s1 <= BUS_RX;
        rx_s2 <= rx_s1;
        rx_s3 <= rx_s2;
        if (rx_s2 == rx_s3)
            rx_level <= rx_s3;
    end
end

// Falling edge of the agreed level is a resynchronisation point
wire rx_fall = rx_level && (rx_s2 == rx_s3) && !rx_s3;

// ----------------------------------------------------------------------------
// Quantum prescaler and bit segment counter
// ----------------------------------------------------------------------------
reg  [`CCTL_DIV_W-1:0] pre_cnt;
reg  [4:0]             q_cnt;
wire                   q_last_pre = (pre_cnt == divisor - 6'h01);
// Total quanta = seg1 + seg2 + sync
wire [4:0]             bit_quanta = {1'b0, seg1} + {2'b00, seg2} + `CCTL_SYNC_QUANTA;
wire [4:0]             sample_q   = {1'b0, seg1}; // quantum index ending phase 1
wire [4:0]             sjw_q      = {3'b000, sjw} + 5'h01;
reg  [4:0]             next_q;

always @* begin
    next_q = q_cnt + 5'h01;
    if (next_q >= bit_quanta)
        next_q = 5'h00;
end

// Counting stops while disabled; the position is kept, not cleared
always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
        pre_cnt      <= 6'h00;
        q_cnt        <= 5'h00;
        QUANTUM_TICK <= 1'b0;
        SAMPLE_POINT <= 1'b0;
        BIT_END      <= 1'b0;
    end else begin
        QUANTUM_TICK <= 1'b0;
        SAMPLE_POINT <= 1'b0;
        BIT_END      <= 1'b0;
        if (ENABLED) begin
            if (rx_fall && q_cnt > sample_q && (bit_quanta - q_cnt) <= sjw_q) begin
                // Early edge in phase 2: shorten by at most the jump width
                pre_cnt <= 6'h00;
                q_cnt   <= 5'h00;
                BIT_END <= 1'b1;
            end else if (q_last_pre) begin
                pre_cnt      <= 6'h00;
                QUANTUM_TICK <= 1'b1;
                q_cnt        <= next_q;
                SAMPLE_POINT <= (q_cnt == sample_q);
                BIT_END      <= (next_q == 5'h00);
            end else begin
                pre_cnt <= pre_cnt + 6'h01;
            end
        end
    end
end

// Pending transmissions start at the first bit boundary after enable
// A frame that becomes pending while disabled simply waits; nothing is dropped
always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN)
        TX_START <= 1'b0;
    else
        TX_START <= ENABLED && OBJ_TX_PENDING && BIT_END;
end

// ----------------------------------------------------------------------------
// Error counters
// ----------------------------------------------------------------------------
// Steps only count while the controller takes part in bus traffic
wire       tx_inc_live = TX_ERR_INC & ENABLED;
wire       tx_dec_live = TX_ERR_DEC & ENABLED;
wire       rx_inc_live = RX_ERR_INC & ENABLED;
wire       rx_dec_live = RX_ERR_DEC & ENABLED;
wire [7:0] next_tx_err = err_step(TX_ERR_COUNT, tx_inc_live, tx_dec_live);
wire [7:0] next_rx_err = err_step(RX_ERR_COUNT, rx_inc_live, rx_dec_live);

// The flag is taken from the next count so it never lags the count by a cycle
always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
        TX_ERR_COUNT <= 8'h00;
        RX_ERR_COUNT <= 8'h00;
        ERR_PASSIVE  <= 1'b0;
    end else begin
        TX_ERR_COUNT <= next_tx_err;
        RX_ERR_COUNT <= next_rx_err;
        ERR_PASSIVE  <= (next_rx_err >= `CCTL_PASSIVE_LIM);
    end
end

// ----------------------------------------------------------------------------
// Interrupt pending flags: a new event wins over a clear in the same cycle
// ----------------------------------------------------------------------------
// Numbers outside 1..32 give an empty mask, so a bad number clears nothing
wire [`CCTL_NOBJ-1:0] obj_clr_req  = INT_CLEAR ? obj_mask(INT_CLEAR_ID) : {`CCTL_NOBJ{1'b0}};
wire [`CCTL_NOBJ-1:0] obj_clr_read = OBJ_READ ? obj_mask(OBJ_READ_ID) : {`CCTL_NOBJ{1'b0}};
wire [`CCTL_NOBJ-1:0] obj_clr      = obj_clr_req | obj_clr_read;
// Status pending clears by its own identifier or by a status read
wire                  stat_clr_req = INT_CLEAR && (INT_CLEAR_ID == `CCTL_STATUS_ID);
wire                  stat_clr     = stat_clr_req || STATUS_READ;

always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
        OBJ_INT_PENDING    <= {`CCTL_NOBJ{1'b0}};
        STATUS_INT_PENDING <= 1'b0;
    end else begin
        OBJ_INT_PENDING    <= (OBJ_INT_PENDING & ~obj_clr) | OBJ_EVENT;
        STATUS_INT_PENDING <= (STATUS_INT_PENDING & ~stat_clr) | STATUS_EVENT;
    end
end

// ----------------------------------------------------------------------------
// Cause and interrupt output
// ----------------------------------------------------------------------------
integer i;
reg [`CCTL_ID_W-1:0] next_cause;
reg                  next_int;
wire [`CCTL_NOBJ-1:0] obj_live = OBJ_INT_PENDING & OBJ_INT_EN;
// Masked sources still record pending; only the request line is gated
wire                  stat_live = STATUS_INT_PENDING && STATUS_INT_EN;

always @* begin
    next_cause = `CCTL_NO_INT;
    // Scan from the top so the lowest numbered object is left last
    for (i = `CCTL_NOBJ - 1; i >= 0; i = i - 1) begin
        if (OBJ_INT_PENDING[i])
            next_cause = i[`CCTL_ID_W-1:0] + 6'h01;
    end
    if (STATUS_INT_PENDING)
        next_cause = `CCTL_STATUS_ID;
    next_int = GLOBAL_INT_EN && (stat_live || (|obj_live));
end

always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
        INT_CAUSE <= `CCTL_NO_INT;
        INT_OUT   <= 1'b0;
    end else begin
        INT_CAUSE <= next_cause;
        INT_OUT   <= next_int;
    end
end

endmodule

// *** rtl/cctl_defs.vh ***
// Constants for the controller area network control and timing block
`ifndef CCTL_DEFS_VH
`define CCTL_DEFS_VH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define CCTL_SEG1_W      4
`define CCTL_SEG2_W      3
`define CCTL_SJW_W       2
`define CCTL_DIV_W       6
`define CCTL_NOBJ        32
`define CCTL_ID_W        6

// ----------------------------------------------------------------------------
// Codes and limits
// ----------------------------------------------------------------------------
`define CCTL_STATUS_ID   6'h20
`define CCTL_STATUS_CODE 6'h21
`define CCTL_NO_INT      6'h00
`define CCTL_PASSIVE_LIM 8'h80
`define CCTL_SYNC_QUANTA 5'h01

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CCTL_RST_SEG1    4'h3
`define CCTL_RST_SEG2    3'h2
`define CCTL_RST_SJW     2'h0
`define CCTL_RST_DIV     6'h01

`endif

// *** verif/cctl_bus_node.sv ***
// Model of another node on the shared bus
`timescale 1ns/1ps
module cctl_bus_node (
    // Clock and command
    input  wire clock,
    input  wire go,
    // Bus level, recessive high once released
    output reg  bus_rx
);
    reg [1:0] cnt = 2'h0;
    initial bus_rx = 1'b1;
    // Dominant for three cycles, then back to the pull-up level
    always @(posedge clock) begin
        if (go)
            cnt <= 2'h3;
        else if (cnt != 2'h0)
            cnt <= cnt - 2'h1;
        bus_rx <= !(go || cnt > 2'h1);
    end
endmodule

// *** verif/cctl_checker.sv ***
// Port assertions for the control and timing block
`timescale 1ns/1ps
`include "cctl_defs.vh"
module cctl_checker (
    // Clock, reset and controls
    input wire CLOCK, RSTN, ENABLE_SET, DISABLE_SET, OBJ_TX_PENDING, GLOBAL_INT_EN,
    input wire STATUS_EVENT, STATUS_READ,
    // Observed outputs
    input wire ENABLED, PROCESS_EN, TX_START, QUANTUM_TICK, BIT_END, ERR_PASSIVE,
    input wire STATUS_INT_PENDING, INT_OUT,
    input wire [7:0] RX_ERR_COUNT,
    input wire [`CCTL_ID_W-1:0] INT_CAUSE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    a_stay_disabled: assert property (!ENABLED && !ENABLE_SET |=> !ENABLED)
        else $error("enabled without request");
    a_enable_take: assert property (ENABLE_SET |=> ENABLED)
        else $error("enable not taken");
    a_disable_take: assert property (DISABLE_SET && !ENABLE_SET |=> !ENABLED)
        else $error("disable not taken");
    a_frozen_timing: assert property ((!ENABLED) [*2] |-> !QUANTUM_TICK && !BIT_END)
        else $error("timing runs while disabled");
    a_process_copy: assert property (PROCESS_EN == ENABLED)
        else $error("process enable differs");
    a_passive_flag: assert property (ERR_PASSIVE == (RX_ERR_COUNT >= `CCTL_PASSIVE_LIM))
        else $error("passive flag wrong");
    a_tx_cause: assert property (TX_START |-> $past(BIT_END) && $past(ENABLED)
        && $past(OBJ_TX_PENDING))
        else $error("transmit start without cause");
    a_global_gate: assert property (!$past(GLOBAL_INT_EN) |-> !INT_OUT)
        else $error("interrupt with global enable off");
    a_status_read: assert property (STATUS_READ && !STATUS_EVENT |=> !STATUS_INT_PENDING)
        else $error("status read kept pending");
    a_cause_status: assert property ($past(STATUS_INT_PENDING)
        |-> INT_CAUSE == `CCTL_STATUS_ID)
        else $error("cause not status id");
    c_tx: cover property (TX_START);
    c_passive: cover property ($rose(ERR_PASSIVE));
    c_status: cover property (STATUS_READ && STATUS_INT_PENDING);
endmodule
bind cctl_ctrl cctl_checker chk (.CLOCK(CLOCK), .RSTN(RSTN), .ENABLE_SET(ENABLE_SET),
    .DISABLE_SET(DISABLE_SET), .OBJ_TX_PENDING(OBJ_TX_PENDING), .GLOBAL_INT_EN(GLOBAL_INT_EN),
    .STATUS_EVENT(STATUS_EVENT), .STATUS_READ(STATUS_READ), .ENABLED(ENABLED),
    .PROCESS_EN(PROCESS_EN), .TX_START(TX_START), .QUANTUM_TICK(QUANTUM_TICK),
    .BIT_END(BIT_END), .ERR_PASSIVE(ERR_PASSIVE), .STATUS_INT_PENDING(STATUS_INT_PENDING),
    .INT_OUT(INT_OUT), .RX_ERR_COUNT(RX_ERR_COUNT), .INT_CAUSE(INT_CAUSE));

// *** verif/tb_top.sv ***
// Self-checking bench for the control and timing block
`timescale 1ns/1ps
`include "cctl_defs.vh"
module tb_top;
    reg         clock = 1'b0, rstn = 1'b0, en_set = 1'b0, dis_set = 1'b0, t_wr = 1'b0;
    reg         go = 1'b0, tx_inc = 1'b0, tx_dec = 1'b0, rx_inc = 1'b0, rx_dec = 1'b0;
    reg         st_ev = 1'b0, tx_pend = 1'b0, clr = 1'b0, st_rd = 1'b0, ob_rd = 1'b0;
    reg         st_en = 1'b0, g_en = 1'b0;
    reg [3:0]   s1 = 4'h3;
    reg [2:0]   s2 = 3'h2;
    reg [1:0]   sjw = 2'h0;
    reg [5:0]   dv = 6'h01, clr_id = 6'h00, rd_id = 6'h00;
    reg [31:0]  ob_ev = 32'h0, ob_en = 32'h0, m;
    wire        bus_rx, enabled, tx_start, qtick, bit_end, passive, st_pend, int_out, spt;
    wire [7:0]  tx_cnt, rx_cnt;
    wire [5:0]  cause;
    wire [31:0] ob_pend;
    int         errors = 0, n_compared = 0, n, k, d;
    cctl_ctrl dut (.CLOCK(clock), .RSTN(rstn), .ENABLE_SET(en_set), .DISABLE_SET(dis_set),
        .TIMING_WRITE(t_wr), .PROP_PHASE1_QUANTA(s1), .PHASE2_QUANTA(s2),
        .RESYNC_JUMP_WIDTH(sjw), .QUANTUM_DIVISOR(dv), .BUS_RX(bus_rx), .TX_ERR_INC(tx_inc),
        .TX_ERR_DEC(tx_dec), .RX_ERR_INC(rx_inc), .RX_ERR_DEC(rx_dec), .STATUS_EVENT(st_ev),
        .OBJ_EVENT(ob_ev), .OBJ_TX_PENDING(tx_pend), .INT_CLEAR(clr), .INT_CLEAR_ID(clr_id),
        .STATUS_READ(st_rd), .OBJ_READ(ob_rd), .OBJ_READ_ID(rd_id), .STATUS_INT_EN(st_en),
        .OBJ_INT_EN(ob_en), .GLOBAL_INT_EN(g_en), .ENABLED(enabled), .PROCESS_EN(),
        .TX_START(tx_start), .QUANTUM_TICK(qtick), .SAMPLE_POINT(spt), .BIT_END(bit_end),
        .TX_ERR_COUNT(tx_cnt), .RX_ERR_COUNT(rx_cnt), .ERR_PASSIVE(passive), .INT_CAUSE(cause),
        .OBJ_INT_PENDING(ob_pend), .STATUS_INT_PENDING(st_pend), .INT_OUT(int_out));
    cctl_bus_node bus (.clock(clock), .go(go), .bus_rx(bus_rx));
    always #5 clock = ~clock;
    task automatic step(input int c = 1);
        repeat (c) @(posedge clock);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic chkn(input string nm, input int e, input int g);
        chk(nm, e, g);
    endtask
    task automatic wrap_up();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Cycles between two pulses; gives up so a dead counter cannot hang the run
    task automatic gap(input bit sel, output int c);
        c = 0;
        while ((sel ? bit_end : qtick) !== 1'b1 && c < 3000) begin
            step();
            c++;
        end
        c = 0;
        do begin
            step();
            c++;
        end while ((sel ? bit_end : qtick) !== 1'b1 && c < 3000);
    endtask
    task automatic onoff(input bit e);
        {en_set, dis_set} = {e, !e};
        step();
        {en_set, dis_set} = 2'b00;
        step();
    endtask
    task automatic prog(input logic [3:0] a, input logic [2:0] b, input logic [5:0] v);
        {s1, s2, dv, sjw} = {a, b, v, 2'($urandom)};
        t_wr = 1'b1;
        step();
        t_wr = 1'b0;
        step();
    endtask
    task automatic bump(input int c, input int sel);
        {tx_inc, rx_inc, rx_dec, tx_dec} = 4'h8 >> sel;
        step(c);
        {tx_inc, rx_inc, rx_dec, tx_dec} = 4'h0;
        step();
    endtask
    task automatic clear(input logic [5:0] id);
        {clr_id, clr} = {id, 1'b1};
        step();
        clr = 1'b0;
        step();
    endtask
    function automatic int bitlen(input int a, input int b, input int v);
        return (a + b + 1) * (v == 0 ? 1 : v);
    endfunction
    function automatic logic [5:0] lowest(input logic [31:0] x);
        lowest = 6'h00;
        for (int i = 31; i >= 0; i--)
            if (x[i]) lowest = 6'(i + 1);
    endfunction
    initial begin
        #500000;
        errors++;
        wrap_up();
    end
    initial begin
        k = $urandom(7013);
        step(20);
        rstn = 1'b1;
        step(30);
        chk("enabled", 0, enabled);
        for (k = 1; k <= 32; k++) clear(6'(k));
        for (k = 0; k < 6; k++) begin
            onoff(0);
            d = (k == 0) ? 0 : $urandom_range(1, 4);
            prog(k == 1 ? 4'hF : 4'($urandom_range(1, 15)), 3'($urandom_range(1, 7)), 6'(d));
            onoff(1);
            gap(1, n);
            chkn("bit cycles", bitlen(s1, s2, d), n);
            n = 0;
            do begin step(); n++; end while (spt !== 1'b1 && n < 3000);
            chkn("sample cycles", (s1 + 1) * (d == 0 ? 1 : d), n);
            gap(0, n);
            chkn("quantum cycles", d == 0 ? 1 : d, n);
        end
        k = bitlen(s1, s2, d);
        prog(4'h1, 3'h1, 6'h01);
        gap(1, n);
        chkn("locked timing", k, n);
        {go, tx_pend} = 2'b11;
        step();
        go = 1'b0;
        gap(1, n);
        chkn("resync bit", 1, int'(n <= k));
        step();
        chk("tx start", 1, tx_start);
        $display("test timing done");
        onoff(0);
        gap(1, n);
        chkn("bit while off", 3000, n);
        bump(5, 1);
        chk("rx while off", 0, rx_cnt);
        onoff(1);
        d = $urandom_range(2, 60);
        bump(d, 0);
        bump(127, 1);
        chk("passive low", 0, passive);
        onoff(0);
        onoff(1);
        chk("tx kept", d, tx_cnt);
        bump(1, 3);
        bump(1, 1);
        chk("tx count", d - 1, tx_cnt);
        chk("passive", 1, passive);
        bump(1, 2);
        chk("passive cleared", 0, passive);
        $display("test errors done");
        {g_en, st_en, ob_en} = {2'b11, 32'hFFFFFFFF};
        for (k = 0; k < 4; k++) begin
            m = (k == 0) ? 32'h80000000 : $urandom;
            ob_ev = m;
            step();
            ob_ev = 32'h0;
            step(2);
            chk("cause", lowest(m), cause);
            chk("irq", m != 0, int_out);
            clear(lowest(m));
            m = m & (m - 1);
            {rd_id, ob_rd} = {lowest(m), 1'b1};
            step();
            ob_rd = 1'b0;
            m = m & (m - 1);
            {st_en, ob_en} = 33'h0;
            step(2);
            chk("pending", m, ob_pend);
            chk("irq masked", 0, int_out);
            {g_en, st_en, ob_en} = {2'b01, 32'hFFFFFFFF};
            step(2);
            chk("irq global off", 0, int_out);
            g_en = 1'b1;
            for (d = 1; d <= 32; d++) clear(6'(d));
            st_ev = 1'b1;
            step();
            st_ev = 1'b0;
            step(2);
            chk("status cause", `CCTL_STATUS_ID, cause);
            clear(6'h21);
            chk("bad id", 1, st_pend);
            if (k[0]) clear(`CCTL_STATUS_ID);
            else st_rd = 1'b1;
            step();
            st_rd = 1'b0;
            step();
            chk("status cleared", 0, st_pend);
        end
        $display("test interrupts done");
        wrap_up();
    end
endmodule
